// [core/lmi_consts.vh]
// Purpose: constants for the literal, move, indirect and return executor
// Assumes: 14-bit instruction words, 8-bit data, 16-bit data space
// Notes:   opcode masks, bus offsets and the byte, option, power control and pointer reset values live here
`ifndef LMI_CONSTS_VH
`define LMI_CONSTS_VH

// ============================================================
// instruction decode (mask, match)
`define LMI_OP_BANK_MASK   14'h3ff0
`define LMI_OP_BANK_VAL    14'h0020
`define LMI_OP_PAGE_MASK   14'h3f80
`define LMI_OP_PAGE_VAL    14'h3180
`define LMI_OP_ACCL_MASK   14'h3f00
`define LMI_OP_ACCL_VAL    14'h3000
`define LMI_OP_WF_MASK     14'h3f80
`define LMI_OP_WF_VAL      14'h0080
`define LMI_OP_WIM_MASK    14'h3ff8
`define LMI_OP_WIM_VAL     14'h0018
`define LMI_OP_WIK_MASK    14'h3f80
`define LMI_OP_WIK_VAL     14'h3f80
`define LMI_OP_FULL_MASK   14'h3fff
`define LMI_OP_OPTION      14'h0062
`define LMI_OP_SWRESET     14'h0001
`define LMI_OP_RETINT      14'h0009

// ============================================================
// operand fields
`define LMI_F_PTRSEL_MODE  2
`define LMI_F_PTRSEL_REL   6
`define LMI_MODE_PREINC    2'h0
`define LMI_MODE_PREDEC    2'h1
`define LMI_MODE_POSTINC   2'h2
`define LMI_MODE_POSTDEC   2'h3
`define LMI_WINDOW0_FILE   7'h00
`define LMI_WINDOW1_FILE   7'h01
`define LMI_GIE_BIT        7
`define LMI_RI_N_BIT       2

// ============================================================
// register bus offsets
`define LMI_REG_ACC        4'h0
`define LMI_REG_BANK       4'h1
`define LMI_REG_PROGRAM_COUNTER_HIGH_LATCH     4'h2
`define LMI_REG_OPTIONS    4'h3
`define LMI_REG_FSR0L      4'h4
`define LMI_REG_FSR0H      4'h5
`define LMI_REG_FSR1L      4'h6
`define LMI_REG_FSR1H      4'h7
`define LMI_REG_INTERRUPT_CONTROL_REGISTER     4'h8
`define LMI_REG_POWER_CONTROL_REGISTER       4'h9
`define LMI_REG_STATUS     4'ha
`define LMI_REG_PCL        4'hb
`define LMI_REG_PCH        4'hc

// ============================================================
// reset values
`define LMI_RST_BYTE       8'h00
`define LMI_RST_OPTIONS    8'hff
`define LMI_RST_POWER_CONTROL_REGISTER       8'h04
`define LMI_RST_PTR        16'h0000

`endif

// [core/lmi_exec.v]
// Purpose: executes literal loads, accumulator stores, indirect stores,
//          option load, software reset and return from interrupt
// Assumes: one instruction offered per cycle with I_INSN_VALID; stack
//          and data memory sit outside, same clock
// Notes:   instructions offered while O_BUSY is high are ignored
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "lmi_consts.vh"

module lmi_exec (
  input  wire        I_CLK,
  input  wire        I_ARST_N,
  input  wire        I_INSN_VALID,
  input  wire [13:0] I_INSN,
  input  wire [14:0] I_TOS,
  input  wire [3:0]  I_ADDR,
  input  wire [7:0]  I_WDATA,
  input  wire        I_WR,
  input  wire        I_RD,
  output reg  [7:0]  O_RDATA,
  output reg         O_MEM_WE,
  output reg  [15:0] O_MEM_ADDR,
  output reg  [7:0]  O_MEM_WDATA,
  output reg         O_STACK_POP,
  output reg         O_PC_LOAD,
  output reg  [14:0] O_PC,
  output reg         O_BUSY,
  output reg         O_SW_RESET
);

  // ============================================================
  // state
  localparam [1:0] ST_RUN = 2'b01;
  localparam [1:0] ST_RET = 2'b10;

  reg [1:0]  state_r;
  reg [7:0]  acc_r;
  reg [4:0]  bank_r;
  reg [6:0]  program_counter_high_latch_r;
  reg [7:0]  options_r;
  reg [15:0] fsr0_r;
  reg [15:0] fsr1_r;
  reg [7:0]  interrupt_control_register_r;
  reg [7:0]  power_control_register_r;
  reg [7:0]  status_r;
  reg [14:0] tos_hold_r;

  function match;
    input [13:0] insn;
    input [13:0] mask;
    input [13:0] val;
    begin
      match = ((insn & mask) == val);
    end
  endfunction

  // ============================================================
  // decode
  wire take = I_INSN_VALID && (state_r == ST_RUN) && !O_BUSY;
  wire is_bank = take && match(I_INSN, `LMI_OP_BANK_MASK, `LMI_OP_BANK_VAL);
  wire is_page = take && match(I_INSN, `LMI_OP_PAGE_MASK, `LMI_OP_PAGE_VAL);
  wire is_accl = take && match(I_INSN, `LMI_OP_ACCL_MASK, `LMI_OP_ACCL_VAL);
  wire is_wf   = take && match(I_INSN, `LMI_OP_WF_MASK, `LMI_OP_WF_VAL);
  wire is_wim  = take && match(I_INSN, `LMI_OP_WIM_MASK, `LMI_OP_WIM_VAL);
  wire is_wik  = take && match(I_INSN, `LMI_OP_WIK_MASK, `LMI_OP_WIK_VAL);
  wire is_opt  = take && match(I_INSN, `LMI_OP_FULL_MASK, `LMI_OP_OPTION);
  wire is_swr  = take && match(I_INSN, `LMI_OP_FULL_MASK, `LMI_OP_SWRESET);
  wire is_ret  = take && match(I_INSN, `LMI_OP_FULL_MASK, `LMI_OP_RETINT);

  wire        ind     = is_wim || is_wik;
  wire        ptr_sel = is_wik ? I_INSN[`LMI_F_PTRSEL_REL] : I_INSN[`LMI_F_PTRSEL_MODE];
  wire [15:0] ptr_cur = ptr_sel ? fsr1_r : fsr0_r;
  wire [15:0] eff_addr;
  wire [15:0] ptr_nxt;

  lmi_ptr_calc u_ptr_calc (
    .i_ptr      (ptr_cur),
    .i_mode     (I_INSN[1:0]),
    .i_rel      (is_wik),
    .i_offset   (I_INSN[5:0]),
    .o_eff_addr (eff_addr),
    .o_ptr_nxt  (ptr_nxt)
  );

  // direct file address, window files redirect through a pointer
  wire [6:0]  file_f    = I_INSN[6:0];
  wire        win0      = (file_f == `LMI_WINDOW0_FILE);
  wire        win1      = (file_f == `LMI_WINDOW1_FILE);
  wire [15:0] file_addr = win0 ? fsr0_r :
                          win1 ? fsr1_r :
                          {4'h0, bank_r, file_f};

  wire bus_wr = I_WR && !is_swr;

  // ============================================================
  // instruction effects and register bus writes
  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_r     <= ST_RUN;
      acc_r       <= `LMI_RST_BYTE;
      bank_r      <= 5'h00;
      program_counter_high_latch_r    <= 7'h00;
      options_r   <= `LMI_RST_OPTIONS;
      fsr0_r      <= `LMI_RST_PTR;
      fsr1_r      <= `LMI_RST_PTR;
      interrupt_control_register_r    <= `LMI_RST_BYTE;
      power_control_register_r      <= `LMI_RST_POWER_CONTROL_REGISTER;
      status_r    <= `LMI_RST_BYTE;
      tos_hold_r  <= 15'h0000;
      O_MEM_WE    <= 1'b0;
      O_MEM_ADDR  <= 16'h0000;
      O_MEM_WDATA <= 8'h00;
      O_STACK_POP <= 1'b0;
      O_PC_LOAD   <= 1'b0;
      O_PC        <= 15'h0000;
      O_BUSY      <= 1'b0;
      O_SW_RESET  <= 1'b0;
    end else if (is_swr) begin
      // same values as a hardware reset, except the indicator bit and O_SW_RESET
      state_r     <= ST_RUN;
      acc_r       <= `LMI_RST_BYTE;
      bank_r      <= 5'h00;
      program_counter_high_latch_r    <= 7'h00;
      options_r   <= `LMI_RST_OPTIONS;
      fsr0_r      <= `LMI_RST_PTR;
      fsr1_r      <= `LMI_RST_PTR;
      interrupt_control_register_r    <= `LMI_RST_BYTE;
      power_control_register_r      <= `LMI_RST_POWER_CONTROL_REGISTER & ~(8'h01 << `LMI_RI_N_BIT);
      status_r    <= `LMI_RST_BYTE;
      tos_hold_r  <= 15'h0000;
      O_MEM_WE    <= 1'b0;
      O_MEM_ADDR  <= 16'h0000;
      O_MEM_WDATA <= 8'h00;
      O_STACK_POP <= 1'b0;
      O_PC_LOAD   <= 1'b0;
      O_PC        <= 15'h0000;
      O_BUSY      <= 1'b0;
      O_SW_RESET  <= 1'b1;
    end else begin
      O_MEM_WE    <= 1'b0;
      O_STACK_POP <= 1'b0;
      O_PC_LOAD   <= 1'b0;
      O_SW_RESET  <= 1'b0;

      // software writes first, instruction effects override below
      if (bus_wr) begin
        case (I_ADDR)
          `LMI_REG_ACC:     acc_r         <= I_WDATA;
          `LMI_REG_BANK:    bank_r        <= I_WDATA[4:0];
          `LMI_REG_PROGRAM_COUNTER_HIGH_LATCH:  program_counter_high_latch_r      <= I_WDATA[6:0];
          `LMI_REG_OPTIONS: options_r     <= I_WDATA;
          `LMI_REG_FSR0L:   fsr0_r[7:0]   <= I_WDATA;
          `LMI_REG_FSR0H:   fsr0_r[15:8]  <= I_WDATA;
          `LMI_REG_FSR1L:   fsr1_r[7:0]   <= I_WDATA;
          `LMI_REG_FSR1H:   fsr1_r[15:8]  <= I_WDATA;
          `LMI_REG_INTERRUPT_CONTROL_REGISTER:  interrupt_control_register_r      <= I_WDATA;
          `LMI_REG_POWER_CONTROL_REGISTER:    power_control_register_r        <= I_WDATA;
          `LMI_REG_STATUS:  status_r      <= I_WDATA;
          default: begin
          end
        endcase
      end

      case (state_r)
        ST_RUN: begin
          if (is_bank) begin
            bank_r <= {1'b0, I_INSN[3:0]};
          end
          if (is_page) begin
            program_counter_high_latch_r <= I_INSN[6:0];
          end
          if (is_accl) begin
            acc_r <= I_INSN[7:0];
          end
          if (is_wf) begin
            O_MEM_WE    <= 1'b1;
            O_MEM_ADDR  <= file_addr;
            O_MEM_WDATA <= acc_r;
          end
          if (ind) begin
            O_MEM_WE    <= 1'b1;
            O_MEM_ADDR  <= eff_addr;
            O_MEM_WDATA <= acc_r;
            // status_r untouched by the pointer step
            if (ptr_sel) begin
              fsr1_r <= ptr_nxt;
            end else begin
              fsr0_r <= ptr_nxt;
            end
          end
          if (is_opt) begin
            options_r <= acc_r;
          end
          if (is_ret) begin
            tos_hold_r <= I_TOS;
            O_BUSY     <= 1'b1;
            state_r    <= ST_RET;
          end
        end
        ST_RET: begin
          O_STACK_POP <= 1'b1;
          O_PC_LOAD   <= 1'b1;
          O_PC        <= tos_hold_r;
          interrupt_control_register_r[`LMI_GIE_BIT] <= 1'b1;
          O_BUSY      <= 1'b0;
          state_r     <= ST_RUN;
        end
        default: begin
          state_r <= ST_RUN;
          O_BUSY  <= 1'b0;
        end
      endcase
    end
  end

  // ============================================================
  // register bus read, data one cycle after the strobe
  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_RDATA <= 8'h00;
    end else if (I_RD) begin
      case (I_ADDR)
        `LMI_REG_ACC:     O_RDATA <= acc_r;
        `LMI_REG_BANK:    O_RDATA <= {3'h0, bank_r};
        `LMI_REG_PROGRAM_COUNTER_HIGH_LATCH:  O_RDATA <= {1'b0, program_counter_high_latch_r};
        `LMI_REG_OPTIONS: O_RDATA <= options_r;
        `LMI_REG_FSR0L:   O_RDATA <= fsr0_r[7:0];
        `LMI_REG_FSR0H:   O_RDATA <= fsr0_r[15:8];
        `LMI_REG_FSR1L:   O_RDATA <= fsr1_r[7:0];
        `LMI_REG_FSR1H:   O_RDATA <= fsr1_r[15:8];
        `LMI_REG_INTERRUPT_CONTROL_REGISTER:  O_RDATA <= interrupt_control_register_r;
        `LMI_REG_POWER_CONTROL_REGISTER:    O_RDATA <= power_control_register_r;
        `LMI_REG_STATUS:  O_RDATA <= status_r;
        `LMI_REG_PCL:     O_RDATA <= O_PC[7:0];
        `LMI_REG_PCH:     O_RDATA <= {1'b0, O_PC[14:8]};
        default:          O_RDATA <= 8'h00;
      endcase
    end else begin
      O_RDATA <= 8'h00;
    end
  end

endmodule // lmi_exec
`default_nettype wire

// [core/lmi_ptr_calc.v]
// Purpose: effective address and updated value of a file-select pointer
// Assumes: pointer arithmetic is 16-bit and wraps
// Notes:   purely combinational, touches no status flag
`timescale 1ns/10ps
`default_nettype none
`include "lmi_consts.vh"

module lmi_ptr_calc (
  input  wire [15:0] i_ptr,
  input  wire [1:0]  i_mode,
  input  wire        i_rel,
  input  wire [5:0]  i_offset,
  output reg  [15:0] o_eff_addr,
  output reg  [15:0] o_ptr_nxt
);

  // ============================================================
  // arithmetic
  always @* begin
    o_eff_addr = i_ptr;
    o_ptr_nxt  = i_ptr;
    if (i_rel) begin
      o_eff_addr = i_ptr + {{10{i_offset[5]}}, i_offset};
    end else begin
      case (i_mode)
        `LMI_MODE_PREINC: begin
          o_eff_addr = i_ptr + 16'h0001;
          o_ptr_nxt  = i_ptr + 16'h0001;
        end
        `LMI_MODE_PREDEC: begin
          o_eff_addr = i_ptr - 16'h0001;
          o_ptr_nxt  = i_ptr - 16'h0001;
        end
        `LMI_MODE_POSTINC: begin
          o_ptr_nxt  = i_ptr + 16'h0001;
        end
        default: begin
          o_ptr_nxt  = i_ptr - 16'h0001;
        end
      endcase
    end
  end

endmodule // lmi_ptr_calc
`default_nettype wire

// [verif/lmi_exec_assertions.sv]
// Purpose: port-level checks for the instruction executor
// Assumes: single clock, async active-low reset
// Notes:   sees only the top module ports, attached by bind
`timescale 1ns/10ps
`default_nettype none
`include "lmi_consts.vh"

module lmi_exec_chk (
  input wire logic        I_CLK,
  input wire logic        I_ARST_N,
  input wire logic        I_INSN_VALID,
  input wire logic [13:0] I_INSN,
  input wire logic [14:0] I_TOS,
  input wire logic [3:0]  I_ADDR,
  input wire logic [7:0]  I_WDATA,
  input wire logic        I_WR,
  input wire logic        I_RD,
  input wire logic [7:0]  O_RDATA,
  input wire logic        O_MEM_WE,
  input wire logic [15:0] O_MEM_ADDR,
  input wire logic [7:0]  O_MEM_WDATA,
  input wire logic        O_STACK_POP,
  input wire logic        O_PC_LOAD,
  input wire logic [14:0] O_PC,
  input wire logic        O_BUSY,
  input wire logic        O_SW_RESET
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);
  logic take;
  logic ret_t;
  logic is_wf;
  logic is_store;
  assign take  = I_INSN_VALID && !O_BUSY;
  assign ret_t = take && (I_INSN == `LMI_OP_RETINT);
  assign is_wf = (I_INSN & `LMI_OP_WF_MASK) == `LMI_OP_WF_VAL;
  assign is_store = is_wf || ((I_INSN & `LMI_OP_WIM_MASK) == `LMI_OP_WIM_VAL)
                    || ((I_INSN & `LMI_OP_WIK_MASK) == `LMI_OP_WIK_VAL);
  // ============================================================
  // assertions
  chk_ret_seq: assert property (ret_t |=> O_BUSY ##1 (O_STACK_POP && !O_BUSY))
    else $error("return sequence wrong");
  chk_ret_pc: assert property (ret_t |-> ##2 (O_PC == $past(I_TOS, 2)))
    else $error("pc not loaded from stack top");
  chk_pop_pair: assert property (O_STACK_POP |-> O_PC_LOAD && $past(O_BUSY))
    else $error("pop without pc load");
  chk_busy_ignore: assert property (O_BUSY && I_INSN_VALID |=> !O_MEM_WE && !O_SW_RESET && !O_BUSY)
    else $error("instruction taken while busy");
  chk_store_cause: assert property (O_MEM_WE |-> $past(take && is_store))
    else $error("memory write without store");
  chk_wf_addr: assert property (take && is_wf && I_INSN[6:1] != 6'h00 |=> O_MEM_WE && O_MEM_ADDR[6:0] == $past(I_INSN[6:0]) && O_MEM_ADDR[15:12] == 4'h0)
    else $error("direct store address wrong");
  chk_swr_pulse: assert property (take && I_INSN == `LMI_OP_SWRESET |=> O_SW_RESET ##1 !O_SW_RESET)
    else $error("software reset pulse wrong");
  chk_swr_cause: assert property (O_SW_RESET |-> $past(take && I_INSN == `LMI_OP_SWRESET))
    else $error("spurious software reset");
  chk_rdata_idle: assert property (!$past(I_RD) |-> O_RDATA == 8'h00)
    else $error("read data outside read slot");
  cov_ret: cover property (ret_t ##2 O_PC_LOAD);
  cov_swr: cover property (O_SW_RESET);
  cov_busy: cover property (O_BUSY && I_INSN_VALID);
endmodule // lmi_exec_chk

bind lmi_exec lmi_exec_chk lmi_exec_chk_i (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
  .I_INSN_VALID(I_INSN_VALID), .I_INSN(I_INSN), .I_TOS(I_TOS), .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_MEM_WE(O_MEM_WE),
  .O_MEM_ADDR(O_MEM_ADDR), .O_MEM_WDATA(O_MEM_WDATA), .O_STACK_POP(O_STACK_POP),
  .O_PC_LOAD(O_PC_LOAD), .O_PC(O_PC), .O_BUSY(O_BUSY), .O_SW_RESET(O_SW_RESET));
`default_nettype wire

// [verif/tb_top.sv]
// Purpose: self-checking bench for the instruction executor
// Assumes: register bus and instruction port driven at rising edges
// Notes:   flags are watched through the status register
`timescale 1ns/10ps
`default_nettype none
`include "lmi_consts.vh"

module tb_top;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        vld = 1'b0;
  logic [13:0] insn = 14'h0000;
  logic [14:0] top_of_stack = 15'h0000;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata;
  logic        mem_we;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic        pop;
  logic        pc_load;
  logic [14:0] pc;
  logic        busy;
  logic        sw_rst;
  int          fails = 0;
  int          n_checks = 0;

  always #2 clk = ~clk;

  lmi_exec lmi_exec_i (.I_CLK(clk), .I_ARST_N(arst_n), .I_INSN_VALID(vld), .I_INSN(insn),
    .I_TOS(top_of_stack), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .O_MEM_WE(mem_we), .O_MEM_ADDR(mem_addr), .O_MEM_WDATA(mem_wdata), .O_STACK_POP(pop),
    .O_PC_LOAD(pc_load), .O_PC(pc), .O_BUSY(busy), .O_SW_RESET(sw_rst));

  // ============================================================
  // shared tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t ns: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input string m);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 check({8'h00, rdata}, {8'h00, e}, m);
  endtask
  task automatic exec(input logic [13:0] w);
    @(posedge clk);
    vld <= 1'b1;
    insn <= w;
    @(posedge clk);
    vld <= 1'b0;
    #1;
  endtask
  task automatic set_ptr(input int n, input logic [15:0] v);
    bus_wr(n ? `LMI_REG_FSR1L : `LMI_REG_FSR0L, v[7:0]);
    bus_wr(n ? `LMI_REG_FSR1H : `LMI_REG_FSR0H, v[15:8]);
  endtask
  task automatic chk_ptr(input int n, input logic [15:0] e);
    rd_chk(n ? `LMI_REG_FSR1L : `LMI_REG_FSR0L, e[7:0], "pointer low");
    rd_chk(n ? `LMI_REG_FSR1H : `LMI_REG_FSR0H, e[15:8], "pointer high");
  endtask

  // ============================================================
  // scenarios
  task automatic t_reset();
    rd_chk(`LMI_REG_OPTIONS, 8'hff, "options reset");
    rd_chk(`LMI_REG_POWER_CONTROL_REGISTER, 8'h04, "power_control_register reset");
    rd_chk(`LMI_REG_ACC, 8'h00, "acc reset");
    rd_chk(4'hf, 8'h00, "unmapped read");
  endtask
  task automatic t_literals();
    bus_wr(`LMI_REG_STATUS, 8'h1b);
    bus_wr(`LMI_REG_BANK, 8'h1f);
    exec(14'h002f);
    rd_chk(`LMI_REG_BANK, 8'h0f, "bank literal");
    exec(14'h31ff);
    rd_chk(`LMI_REG_PROGRAM_COUNTER_HIGH_LATCH, 8'h7f, "page latch literal");
    exec(14'h30a5);
    rd_chk(`LMI_REG_ACC, 8'ha5, "acc literal");
    rd_chk(`LMI_REG_STATUS, 8'h1b, "flags after literals");
  endtask
  task automatic t_store();
    exec(14'h0022);
    exec(14'h00a3);
    check({15'h0000, mem_we}, 16'h0001, "direct store strobe");
    check(mem_addr, 16'h0123, "direct store address");
    check({8'h00, mem_wdata}, 16'h00a5, "direct store data");
    @(posedge clk);
    #1 check({15'h0000, mem_we}, 16'h0000, "store strobe length");
    set_ptr(0, 16'h1234);
    exec(14'h0080);
    check(mem_addr, 16'h1234, "window redirect");
    set_ptr(1, 16'hbeef);
    exec(14'h0081);
    check(mem_addr, 16'hbeef, "window one redirect");
  endtask
  task automatic t_indirect();
    logic [15:0] p;
    logic [15:0] np;
    logic [15:0] ea;
    logic [5:0]  k;
    for (int m = 0; m < 4; m++) begin
      p = m[0] ? 16'h0000 : 16'hffff;
      np = m[0] ? p - 16'h0001 : p + 16'h0001;
      ea = m[1] ? p : np;
      set_ptr(1, p);
      exec(14'h001c | {12'h000, m[1:0]});
      check(mem_addr, ea, "indirect address");
      check({8'h00, mem_wdata}, 16'h00a5, "indirect data");
      chk_ptr(1, np);
    end
    for (int i = 0; i < 2; i++) begin
      k = i ? 6'h1f : 6'h20;
      set_ptr(0, 16'h0010);
      exec(14'h3f80 | {8'h00, k});
      check(mem_addr, i ? 16'h002f : 16'hfff0, "offset address");
      chk_ptr(0, 16'h0010);
    end
    rd_chk(`LMI_REG_STATUS, 8'h1b, "flags after indirect");
  endtask
  task automatic t_option();
    exec(14'h303c);
    exec(`LMI_OP_OPTION);
    rd_chk(`LMI_REG_OPTIONS, 8'h3c, "options load");
  endtask
  task automatic t_return();
    bus_wr(`LMI_REG_INTERRUPT_CONTROL_REGISTER, 8'h00);
    @(posedge clk);
    vld <= 1'b1;
    insn <= `LMI_OP_RETINT;
    top_of_stack <= 15'h5a5a;
    @(posedge clk);
    insn <= 14'h3077;
    top_of_stack <= 15'h0000;
    #1 check({15'h0000, busy}, 16'h0001, "return first cycle");
    @(posedge clk);
    vld <= 1'b0;
    #1 check({14'h0000, pop, pc_load}, 16'h0003, "pop and load");
    check({1'b0, pc}, 16'h5a5a, "pc from stack top");
    rd_chk(`LMI_REG_INTERRUPT_CONTROL_REGISTER, 8'h80, "interrupt enable set");
    rd_chk(`LMI_REG_PCL, 8'h5a, "pc low readback");
    rd_chk(`LMI_REG_PCH, 8'h5a, "pc high readback");
    rd_chk(`LMI_REG_ACC, 8'h3c, "busy slot ignored");
    rd_chk(`LMI_REG_STATUS, 8'h1b, "flags after return");
  endtask
  task automatic t_swreset();
    exec(`LMI_OP_SWRESET);
    check({15'h0000, sw_rst}, 16'h0001, "software reset pulse");
    check(mem_addr, 16'h0000, "store address after reset");
    check({1'b0, pc}, 16'h0000, "pc after reset");
    rd_chk(`LMI_REG_POWER_CONTROL_REGISTER, 8'h00, "indicator cleared");
    check({15'h0000, sw_rst}, 16'h0000, "software reset pulse length");
    rd_chk(`LMI_REG_BANK, 8'h00, "bank after reset");
    chk_ptr(0, 16'h0000);
    rd_chk(`LMI_REG_ACC, 8'h00, "acc after reset");
    rd_chk(`LMI_REG_OPTIONS, 8'hff, "options after reset");
  endtask

  // ============================================================
  // verdict and sequence
  task automatic results();
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #20000;
    fails++;
    results();
  end

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_literals();
    t_store();
    t_indirect();
    t_option();
    t_return();
    t_swreset();
    results();
  end
endmodule // tb_top
`default_nettype wire
